// ### tmis_top.v
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`include "tmis_map.vh"
module tmis_top
#(
   parameter NT = `TMIS_NUM_TIMERS,
   parameter EW = `TMIS_EVT_W
)
(
   input wire clock_in,
   input wire rst_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [`TMIS_ADDR_W-1:0] paddr_in,
   input wire [`TMIS_DATA_W-1:0] pwdata_in,
   input wire [NT*EW-1:0] events_in,
   output reg [`TMIS_DATA_W-1:0] prdata_out,
   output reg pready_out,
   output reg pslverr_out,
   output wire [NT-1:0] irq_out
);

   // Page decode, used for both the read path and the write path
   function [1:0] tmis_blk;
      input [`TMIS_ADDR_W-1:0] addr;
      begin
         case (addr[`TMIS_PAGE_HI:`TMIS_PAGE_LO])
            `TMIS_BASE0_PAGE: tmis_blk = 2'h0; // RL11
            `TMIS_BASE1_PAGE: tmis_blk = 2'h1; // RL11
            `TMIS_BASE2_PAGE: tmis_blk = 2'h2; // RL11
            default: tmis_blk = `TMIS_NO_BLK;
         endcase
      end
   endfunction

   // Offset check inside one page
   function tmis_ofs_ok;
      input [`TMIS_OFS_HI:0] ofs;
      begin
         case (ofs)
            `TMIS_OFS_MASK: tmis_ofs_ok = 1'b1;
            `TMIS_OFS_RAW: tmis_ofs_ok = 1'b1;
            `TMIS_OFS_MSK_ST: tmis_ofs_ok = 1'b1;
            `TMIS_OFS_CLEAR: tmis_ofs_ok = 1'b1;
            default: tmis_ofs_ok = 1'b0;
         endcase
      end
   endfunction

   wire [1:0] blk_sel;
   wire [`TMIS_OFS_HI:0] reg_ofs;
   wire addr_ok;
   wire setup_phase;
   wire access_done;
   wire wr_commit;

   assign blk_sel = tmis_blk(paddr_in);
   assign reg_ofs = paddr_in[`TMIS_OFS_HI:0];
   assign addr_ok = (blk_sel != `TMIS_NO_BLK) && tmis_ofs_ok(reg_ofs);

   // One wait-free access phase: pready rises on the edge after setup
   assign setup_phase = psel_in && !penable_in && !pready_out;
   assign access_done = psel_in && penable_in && pready_out;

   // Writes land only at the completing edge, and never on an error
   assign wr_commit = access_done && pwrite_in && !pslverr_out;

   reg [EW-1:0] read_word;
   wire [NT*EW-1:0] mask_all;
   wire [NT*EW-1:0] raw_all;
   wire [NT*EW-1:0] msk_st_all;

   genvar t;
   generate
      for (t = 0; t < NT; t = t + 1)
      begin : g_timer
         reg [EW-1:0] enable_mask_r;
         wire [EW-1:0] enable_mask_nxt;
         wire mask_wr;
         wire clr_wr;
         wire [EW-1:0] clr_bits;
         wire [EW-1:0] set_bits;
         wire [EW-1:0] raw_status;

         assign mask_wr = wr_commit && (blk_sel == t) && (reg_ofs == `TMIS_OFS_MASK);
         assign clr_wr = wr_commit && (blk_sel == t) && (reg_ofs == `TMIS_OFS_CLEAR);

         // Reserved lanes never store anything
         assign enable_mask_nxt = mask_wr ?
            (pwdata_in[EW-1:0] & `TMIS_EVT_BITS) : enable_mask_r; // RL1 RL2 RL3 RL4 RL5 RL6 RL12

         always @(posedge clock_in or posedge rst_in)
         begin
            if (rst_in)
            begin
               enable_mask_r <= `TMIS_MASK_RST; // RL1 RL3 RL4 RL5 RL6 RL12
            end
            else
            begin
               enable_mask_r <= enable_mask_nxt;
            end
         end

         // Zeros in the clear word leave the bit alone
         assign clr_bits = clr_wr ? (pwdata_in[EW-1:0] & `TMIS_EVT_BITS) :
            {EW{1'b0}}; // RL14

         // Events are caught regardless of the mask
         assign set_bits = events_in[t*EW +: EW] & `TMIS_EVT_BITS; // RL8

         tmis_sticky #(.W(EW)) u_raw
         (
            .clock_in(clock_in),
            .rst_in(rst_in),
            .set_in(set_bits),
            .clr_in(clr_bits),
            .status_out(raw_status)
         );

         tmis_irqgen #(.W(EW)) u_irq
         (
            .clock_in(clock_in),
            .rst_in(rst_in),
            .status_in(raw_status),
            .enable_in(enable_mask_r),
            .irq_out(irq_out[t])
         );

         assign mask_all[t*EW +: EW] = enable_mask_r;
         assign raw_all[t*EW +: EW] = raw_status; // RL7
         assign msk_st_all[t*EW +: EW] = raw_status & enable_mask_r; // RL13
      end
   endgenerate

   // Read mux: the chosen timer's word at the chosen offset
   always @*
   begin
      read_word = {EW{1'b0}};
      if (addr_ok)
      begin
         case (reg_ofs)
            `TMIS_OFS_MASK: read_word = mask_all[blk_sel*EW +: EW]; // RL2
            `TMIS_OFS_RAW: read_word = raw_all[blk_sel*EW +: EW]; // RL10
            `TMIS_OFS_MSK_ST: read_word = msk_st_all[blk_sel*EW +: EW]; // RL13
            default: read_word = {EW{1'b0}};
         endcase
      end
   end

   reg [`TMIS_DATA_W-1:0] prdata_nxt;
   reg pready_nxt;
   reg pslverr_nxt;

   // Data are captured at the setup edge; clear register reads as zero
   always @*
   begin
      prdata_nxt = prdata_out;
      pready_nxt = 1'b0;
      pslverr_nxt = pslverr_out;
      if (setup_phase)
      begin
         pready_nxt = 1'b1;
         pslverr_nxt = !addr_ok;
         if (pwrite_in)
         begin
            prdata_nxt = `TMIS_RD_ZERO;
         end
         else
         begin
            prdata_nxt = {{`TMIS_PAD_W{1'b0}}, read_word};
         end
      end
      else if (access_done)
      begin
         pslverr_nxt = 1'b0;
      end
   end

   always @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         prdata_out <= `TMIS_RD_ZERO;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end
      else
      begin
         prdata_out <= prdata_nxt;
         pready_out <= pready_nxt;
         pslverr_out <= pslverr_nxt;
      end
   end
endmodule // tmis_top

// ### tmis_map.vh
// What this block does
// RL1 - Mask bit 8 enables timer B time-out interrupt; read/write, resets to 0.
// RL2 - Mask bits 7 to 4 are reserved: read zero, writes ignored.
// RL3 - Mask bit 3 enables clock event interrupt; read/write, resets to 0.
// RL4 - Mask bit 2 enables capture A event interrupt; read/write, resets to 0.
// RL5 - Mask bit 1 enables capture A match interrupt; read/write, resets to 0.
// RL6 - Mask bit 0 enables timer A time-out interrupt; read/write, resets to 0.
// RL7 - Raw status shows whether each internal source event has happened.
// RL8 - A raw status bit sets on its event whatever the mask says.
// RL9 - A raw status bit stays set until software writes 1 to clear it.
// RL10 - Raw status register sits at byte offset 0x01C of each timer.
// RL11 - Three timer register sets at bases 0x4003_0000, 0x4003_1000, 0x4003_2000.
// RL12 - Mask bits 10 and 9 enable capture B event and match; reset 0.
// RL13 - Masked status at 0x020 reads raw status ANDed with mask.
// RL14 - Writing 1 at clear register 0x024 clears raw and masked bits.
// RL15 - Interrupt output is high while any masked status bit is set.
`ifndef TMIS_MAP_VH
`define TMIS_MAP_VH

`define TMIS_NUM_TIMERS 3
`define TMIS_EVT_W 11
`define TMIS_ADDR_W 32
`define TMIS_DATA_W 32

`define TMIS_BASE0_PAGE 20'h4_0030
`define TMIS_BASE1_PAGE 20'h4_0031
`define TMIS_BASE2_PAGE 20'h4_0032
`define TMIS_PAGE_HI 31
`define TMIS_PAGE_LO 12
`define TMIS_OFS_HI 11
`define TMIS_NO_BLK 2'h3

`define TMIS_OFS_MASK 12'h018
`define TMIS_OFS_RAW 12'h01C
`define TMIS_OFS_MSK_ST 12'h020
`define TMIS_OFS_CLEAR 12'h024

`define TMIS_EVT_BITS 11'h70F
`define TMIS_MASK_RST 11'h000
`define TMIS_RAW_RST 11'h000
`define TMIS_RD_ZERO 32'h0000_0000
`define TMIS_PAD_W 21

`define TMIS_BIT_TA_TIMEOUT 0
`define TMIS_BIT_CA_MATCH 1
`define TMIS_BIT_CA_EVENT 2
`define TMIS_BIT_CLK_EVENT 3
`define TMIS_BIT_TB_TIMEOUT 8
`define TMIS_BIT_CB_MATCH 9
`define TMIS_BIT_CB_EVENT 10

`endif

// ### tmis_sticky.v
`timescale 1ns/10ps
`include "tmis_map.vh"
module tmis_sticky
#(
   parameter W = `TMIS_EVT_W
)
(
   input wire clock_in,
   input wire rst_in,
   input wire [W-1:0] set_in,
   input wire [W-1:0] clr_in,
   output reg [W-1:0] status_out
);
   wire [W-1:0] status_nxt;

   // Set wins over a clear in the same cycle so no event is lost
   assign status_nxt = (status_out & ~clr_in) | set_in; // RL8 RL9

   always @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         status_out <= {W{1'b0}};
      end
      else
      begin
         status_out <= status_nxt; // RL7
      end
   end
endmodule // tmis_sticky

// ### tmis_irqgen.v
`timescale 1ns/10ps
`include "tmis_map.vh"
module tmis_irqgen
#(
   parameter W = `TMIS_EVT_W
)
(
   input wire clock_in,
   input wire rst_in,
   input wire [W-1:0] status_in,
   input wire [W-1:0] enable_in,
   output reg irq_out
);
   wire irq_nxt;

   assign irq_nxt = |(status_in & enable_in); // RL15

   always @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         irq_out <= 1'b0;
      end
      else
      begin
         irq_out <= irq_nxt; // RL15
      end
   end
endmodule // tmis_irqgen

// ### tmis_checker.sv
`timescale 1ns/10ps
module tmis_checker
#(
   parameter NT = 3,
   parameter EW = 11
)
(
   input wire clock_in,
   input wire rst_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [31:0] paddr_in,
   input wire [31:0] pwdata_in,
   input wire [NT*EW-1:0] events_in,
   input wire [31:0] prdata_out,
   input wire pready_out,
   input wire pslverr_out,
   input wire [NT-1:0] irq_out
);
   wire [19:0] pg = paddr_in[31:12];
   wire [11:0] ofs = paddr_in[11:0];
   wire done = psel_in & penable_in & pready_out;
   wire wr0 = done & pwrite_in & (pg == 20'h4_0030);
   wire ev0 = |events_in[10:0];
   wire pg_ok = pg >= 20'h4_0030 && pg <= 20'h4_0032;
   wire ofs_ok = ofs == 12'h018 || ofs == 12'h01C || ofs == 12'h020 || ofs == 12'h024;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   sequence s_setup;
      psel_in && !penable_in && !pready_out;
   endsequence
   sequence s_answer;
      pready_out ##1 !pready_out;
   endsequence
   a_ready_after_setup: assert property (s_setup |-> ##1 s_answer)
      else $error("pready pulse wrong after setup");
   a_ready_needs_setup: assert property (pready_out |-> $past(psel_in && !penable_in))
      else $error("pready without setup");
   a_err_unmapped: assert property (done && !pg_ok |-> pslverr_out)
      else $error("no error on unmapped page");
   a_err_mapped: assert property (done && pg_ok && ofs_ok |-> !pslverr_out)
      else $error("error on mapped register");
   a_err_with_ready: assert property (pslverr_out |-> pready_out)
      else $error("pslverr outside answer");
   a_rsvd_zero: assert property (done && !pwrite_in |->
      prdata_out[31:11] == 21'h0 && prdata_out[7:4] == 4'h0)
      else $error("reserved read bits not zero");
   a_irq_rise_cause: assert property ($rose(irq_out[0]) |-> $past(ev0 || wr0, 2))
      else $error("irq rose without cause");
   a_irq_fall_cause: assert property ($fell(irq_out[0]) |-> $past(wr0, 2))
      else $error("irq fell without write");
   a_reset_clean: assert property ($fell(rst_in) |-> irq_out == 0 && !pready_out)
      else $error("outputs busy after reset");
endmodule // tmis_checker
bind tmis_top tmis_checker #(.NT(NT), .EW(EW)) u_chk (.clock_in(clock_in), .rst_in(rst_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .events_in(events_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out));

// ### tmis_evsrc.sv
`timescale 1ns/10ps
module tmis_evsrc
(
   input wire clock_in,
   input wire rst_in,
   input wire go_in,
   input wire [32:0] pat_in,
   input wire [3:0] hold_in,
   output reg [32:0] events_out
);
   reg [3:0] cnt_r;
   // Stretched levels too, since slow sources hold their flag
   always @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cnt_r <= 4'h0;
         events_out <= 33'h0;
      end
      else if (go_in)
      begin
         cnt_r <= hold_in;
         events_out <= pat_in;
      end
      else if (cnt_r > 4'h1)
         cnt_r <= cnt_r - 4'h1;
      else
      begin
         cnt_r <= 4'h0;
         events_out <= 33'h0;
      end
   end
endmodule // tmis_evsrc

// ### tmis_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
   localparam T0 = 32'h4003_0000;
   localparam T1 = 32'h4003_1000;
   localparam T2 = 32'h4003_2000;
   reg clock_in = 1'b0;
   reg rst_in = 1'b1;
   reg psel = 1'b0;
   reg pen = 1'b0;
   reg pwr = 1'b0;
   reg go = 1'b0;
   reg err;
   reg [31:0] paddr = 32'h0;
   reg [31:0] pwdata = 32'h0;
   reg [31:0] rd;
   reg [32:0] pat = 33'h0;
   reg [3:0] hold = 4'h1;
   wire [32:0] ev;
   wire [31:0] prdata;
   wire pready;
   wire perr;
   wire [2:0] irq;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;
   integer i;
   always #10 clock_in = ~clock_in;
   tmis_top DUT (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .events_in(ev),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .irq_out(irq));
   tmis_evsrc src (.clock_in(clock_in), .rst_in(rst_in), .go_in(go), .pat_in(pat),
      .hold_in(hold), .events_out(ev));
   task final_report;
   begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   always @(posedge clock_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         bad_count++;
         final_report;
      end
   end
   task xfer(input w, input [31:0] a, input [31:0] d);
   begin
      @(posedge clock_in);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      pen <= 1'b1;
      do @(posedge clock_in); while (pready !== 1'b1);
      rd = prdata;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   end
   endtask
   task rchk(input [31:0] a, input [31:0] e, input x);
   begin
      xfer(1'b0, a, 32'h0);
      `CHK("rdata", e, rd)
      `CHK("pslverr", x, err)
   end
   endtask
   task fire(input [32:0] p, input [3:0] h);
   begin
      @(posedge clock_in);
      pat <= p;
      hold <= h;
      go <= 1'b1;
      @(posedge clock_in);
      go <= 1'b0;
      repeat (h + 3) @(posedge clock_in);
   end
   endtask
   task t_regs;
   begin
      rchk(T0 + 32'h18, 32'h0, 1'b0);
      rchk(T0 + 32'h1C, 32'h0, 1'b0);
      xfer(1'b1, T1 + 32'h18, 32'hFFFF_FFFF);
      rchk(T1 + 32'h18, 32'h0000_070F, 1'b0);
      for (i = 0; i < 11; i++)
         if (i < 4 || i > 7)
         begin
            xfer(1'b1, T1 + 32'h18, 32'h1 << i);
            rchk(T1 + 32'h18, 32'h1 << i, 1'b0);
         end
      $display("t_regs done");
   end
   endtask
   task t_sticky;
   begin
      xfer(1'b1, T1 + 32'h18, 32'h0);
      fire(33'h7FF << 11, 4'h1);
      rchk(T1 + 32'h1C, 32'h0000_070F, 1'b0);
      rchk(T1 + 32'h20, 32'h0, 1'b0);
      `CHK("irq", 3'h0, irq)
      rchk(T0 + 32'h1C, 32'h0, 1'b0);
      xfer(1'b1, T1 + 32'h24, 32'h0);
      xfer(1'b1, T1 + 32'h1C, 32'h0);
      xfer(1'b1, T1 + 32'h24, 32'h0000_000F);
      rchk(T1 + 32'h1C, 32'h0000_0700, 1'b0);
      $display("t_sticky done");
   end
   endtask
   task t_irq;
   begin
      xfer(1'b1, T0 + 32'h18, 32'h0000_0100);
      fire(33'h100, 4'h3);
      `CHK("irq", 3'h1, irq)
      fire(33'h1, 4'h1);
      rchk(T0 + 32'h20, 32'h0000_0100, 1'b0);
      xfer(1'b1, T0 + 32'h24, 32'h0000_0100);
      repeat (2) @(posedge clock_in);
      `CHK("irq", 3'h0, irq)
      xfer(1'b1, T0 + 32'h18, 32'h0000_0001);
      repeat (2) @(posedge clock_in);
      `CHK("irq", 3'h1, irq)
      rchk(T2 + 32'h1C, 32'h0, 1'b0);
      xfer(1'b1, T0 + 32'h18, 32'h0);
      repeat (2) @(posedge clock_in);
      `CHK("irq", 3'h0, irq)
      $display("t_irq done");
   end
   endtask
   task t_bad;
   begin
      rchk(32'h4003_301C, 32'h0, 1'b1);
      rchk(T0 + 32'h28, 32'h0, 1'b1);
      rchk(T0 + 32'h1D, 32'h0, 1'b1);
      $display("t_bad done");
   end
   endtask
   initial
   begin
      repeat (5) @(posedge clock_in);
      rst_in <= 1'b0;
      t_regs;
      t_sticky;
      t_irq;
      t_bad;
      final_report;
   end
endmodule // testbench
